// >>> hdl/phase_green_ped_timing.sv
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Extension interval setting spans 0 to 9 s in eighth-second steps
// - A zero setting may expire anywhere from 0 to 100 ms
// - Green ceiling counts only in green with a conflicting call registered
// - Ceiling expiry never ends green before minimum green has elapsed
// - Green stays extensible while the extension timer runs, bounded by ceiling
// - Each detection reloads the extension timer and holds it full while active
// - Without a conflicting call the ceiling timer stays in reset
// - With volume density, detections in yellow or red are counted
// - Initial ceiling is fixed 30 s or a 0 to 60 s setting
// - Initial is increment times count, clipped, never below minimum green
// - Pre-reduction delay runs only in green with a conflicting call
// - After the delay, gap falls linearly at (extension minus floor) over span
// - Gap at or below the floor gap holds at the floor
// - Continuously active detection prevents gap termination
// - Losing the conflicting call restores the gap and resets the delay
// - Walk lasts walk setting; clearance and flashing last clearance setting
// - Stored crossing call starts walk with green unless inhibited
// - Green is shown throughout walk and crossing clearance
// - Crossing recycle only without conflicting calls and without inhibit
// - Extension timing runs in parallel with the initial period
module phase_green_ped_timing
	import phase_timing_pkg::*;
#(
	parameter int TICK_DIV = TICK_CYCLES
) (
	// Clock and reset
	input  wire logic        CLK,
	input  wire logic        RSTN,
	// APB slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic [31:0]      PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// Detector, call and sequencer inputs
	input  wire logic        VEH_DET,
	input  wire logic        PED_CALL,
	input  wire logic        CONFLICT_CALL,
	input  wire logic        CROSSING_SERVICE_INHIBIT,
	input  wire logic        PHASE_GO,
	// Indications
	output logic             GREEN,
	output logic             WALK,
	output logic             DONT_WALK_FLASH,
	output logic             PED_CLEARANCE,
	output logic             GREEN_DONE
);

	pins_t                pin_raw;
	pins_t                pin_s1_q;
	pins_t                pin_s2_q;
	pins_t                pin_prev_q;
	cfg_t                 cfg_q;
	cfg_t                 cfg_d;
	phase_t               phase_q;
	phase_t               phase_d;
	ped_t                 ped_q;
	ped_t                 ped_d;
	logic [31:0]          prdata_q;
	logic [31:0]          prdata_d;
	logic [31:0]          rd_word;
	logic [CNT_W-1:0]     count_q;
	logic [CNT_W-1:0]     count_d;
	logic [TW-1:0]        gap_q;
	logic [TW-1:0]        gap_d;
	logic [TW:0]          acc_q;
	logic [TW:0]          acc_d;
	logic                 done_q;
	logic                 done_d;
	logic                 tick;
	logic                 det;
	logic                 conf;
	logic                 inh;
	logic                 green;
	logic                 run_gate;
	logic                 recyc_ok;
	logic                 green_start;
	logic                 det_rise;
	logic                 terminate;
	logic                 gap_out;
	logic                 max_exp;
	logic                 reducing;
	logic                 ped_start;
	logic                 walk_end;
	logic                 init_done;
	logic                 ext_done;
	logic                 max_done;
	logic                 before_done;
	logic                 ped_done;
	logic [TW-1:0]        init_rem;
	logic [TW-1:0]        ext_rem;
	logic [TW-1:0]        max_rem;
	logic [TW-1:0]        before_rem;
	logic [TW-1:0]        ped_rem;
	logic [TW-1:0]        init_val;
	logic [TW-1:0]        init_cap;
	logic [TW-1:0]        gap_diff;
	logic [TW+CNT_W-1:0]  init_prod;
	logic                 wr_en;
	logic                 addr_ok;
	logic                 addr_ro;

	// Common eighth-second time base
	tick_gen #(.DIV(TICK_DIV)) u_tick (
		.clk (CLK),
		.rstn(RSTN),
		.tick(tick)
	);

	// Pins cross into the clock domain through two flops
	assign pin_raw = '{VEH_DET, PED_CALL, CONFLICT_CALL, CROSSING_SERVICE_INHIBIT, PHASE_GO};

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			pin_s1_q   <= '0;
			pin_s2_q   <= '0;
			pin_prev_q <= '0;
		end else begin
			pin_s1_q   <= pin_raw;
			pin_s2_q   <= pin_s1_q;
			pin_prev_q <= pin_s2_q;
		end
	end

	// Decoded conditions; pin levels from the second sync stage, edges against the flop after it
	assign det         = pin_s2_q.veh_det;
	assign conf        = pin_s2_q.conflict;
	assign inh         = pin_s2_q.inhibit;
	assign green       = (phase_q == PH_GREEN);
	assign run_gate    = green && conf;
	assign recyc_ok    = !conf && !inh;
	assign det_rise    = det && !pin_prev_q.veh_det;
	assign green_start = (phase_q == PH_OFF) && pin_s2_q.phase_go && !pin_prev_q.phase_go;

	// APB decode; registers answer in zero wait states
	always_comb begin
		rd_word = '0;
		addr_ok = 1'b1;
		addr_ro = 1'b0;
		case (PADDR)
			OFS_CTRL: begin
				rd_word[CTRL_VD_BIT]  = cfg_q.vol_density;
				rd_word[CTRL_MIS_BIT] = cfg_q.max_init_set;
			end
			OFS_MIN_GREEN:   rd_word[TW-1:0] = cfg_q.min_green;
			OFS_PASSAGE:     rd_word[TW-1:0] = cfg_q.passage;
			OFS_MAX_GREEN:   rd_word[TW-1:0] = cfg_q.max_green;
			OFS_WALK:        rd_word[TW-1:0] = cfg_q.walk;
			OFS_PED_CLEAR:   rd_word[TW-1:0] = cfg_q.ped_clear;
			OFS_ADDED_INIT:  rd_word[TW-1:0] = cfg_q.added_init;
			OFS_REDUCE_SPAN: rd_word[TW-1:0] = cfg_q.reduce_span;
			OFS_BEFORE_RED:  rd_word[TW-1:0] = cfg_q.before_red;
			OFS_MIN_GAP:     rd_word[TW-1:0] = cfg_q.min_gap;
			OFS_MAX_INIT:    rd_word[TW-1:0] = cfg_q.max_init;
			OFS_STATUS: begin
				addr_ro                           = 1'b1;
				rd_word[ST_GREEN_BIT]             = green;
				rd_word[ST_WALK_BIT]              = (ped_q == PD_WALK);
				rd_word[ST_CLEAR_BIT]             = (ped_q == PD_CLEAR);
				rd_word[ST_MAXOUT_BIT]            = max_exp;
				rd_word[ST_GAPOUT_BIT]            = gap_out;
				rd_word[ST_REDUCE_BIT]            = reducing;
				rd_word[ST_MINOK_BIT]             = init_done;
				rd_word[ST_GAP_LSB +: TW]         = gap_q;
			end
			OFS_COUNT: begin
				addr_ro              = 1'b1;
				rd_word[CNT_W-1:0]   = count_q;
			end
			default: addr_ok = 1'b0;
		endcase
	end

	assign wr_en   = PSEL && PENABLE && PWRITE && addr_ok && !addr_ro;
	assign PREADY  = 1'b1;
	assign PSLVERR = PSEL && PENABLE && (!addr_ok || (PWRITE && addr_ro));

	// Settings; all times held in eighths so quarter steps are exact
	always_comb begin
		cfg_d = cfg_q;
		if (wr_en) begin
			case (PADDR)
				OFS_CTRL: begin
					cfg_d.vol_density  = PWDATA[CTRL_VD_BIT];
					cfg_d.max_init_set = PWDATA[CTRL_MIS_BIT];
				end
				OFS_MIN_GREEN:   cfg_d.min_green   = PWDATA[TW-1:0];
				OFS_PASSAGE:     cfg_d.passage     = PWDATA[TW-1:0];
				OFS_MAX_GREEN:   cfg_d.max_green   = PWDATA[TW-1:0];
				OFS_WALK:        cfg_d.walk        = PWDATA[TW-1:0];
				OFS_PED_CLEAR:   cfg_d.ped_clear   = PWDATA[TW-1:0];
				OFS_ADDED_INIT:  cfg_d.added_init  = PWDATA[TW-1:0];
				OFS_REDUCE_SPAN: cfg_d.reduce_span = PWDATA[TW-1:0];
				OFS_BEFORE_RED:  cfg_d.before_red  = PWDATA[TW-1:0];
				OFS_MIN_GAP:     cfg_d.min_gap     = PWDATA[TW-1:0];
				OFS_MAX_INIT:    cfg_d.max_init    = PWDATA[TW-1:0];
				default: ;
			endcase
		end
	end

	// Read data captured in the setup phase, stable through access
	always_comb begin
		prdata_d = prdata_q;
		if (PSEL && !PENABLE && !PWRITE) begin
			prdata_d = rd_word;
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			cfg_q    <= CFG_RST;
			prdata_q <= '0;
		end else begin
			cfg_q    <= cfg_d;
			prdata_q <= prdata_d;
		end
	end

	assign PRDATA = prdata_q;

	// Detections outside green build the scaled initial
	always_comb begin
		count_d = count_q;
		if (green_start) begin
			count_d = '0;
		end else if (!green && cfg_q.vol_density && det_rise && count_q != '1) begin
			count_d = count_q + CNT_W'(1);
		end
	end

	// Initial period; minimum green overrides a low ceiling
	always_comb begin
		init_prod = (TW+CNT_W)'(cfg_q.added_init) * (TW+CNT_W)'(count_q);
		init_cap  = cfg_q.max_init_set ? cfg_q.max_init : MAX_INIT_FIXED;
		init_val  = cfg_q.min_green;
		if (cfg_q.vol_density) begin
			init_val = lim_max(lim_clip(init_prod, init_cap), cfg_q.min_green);
		end
	end

	// Gap reduction: add the difference each tick, step one eighth per span spent.
	// Steps drain between ticks, so the fall is exact without a divider.
	assign gap_diff = (cfg_q.passage > cfg_q.min_gap) ? cfg_q.passage - cfg_q.min_gap : '0;
	assign reducing = cfg_q.vol_density && run_gate && before_done;

	always_comb begin
		gap_d = gap_q;
		acc_d = acc_q;
		if (!reducing) begin
			gap_d = cfg_q.passage;
			acc_d = '0;
		end else if (gap_q <= cfg_q.min_gap || cfg_q.reduce_span == '0) begin
			gap_d = cfg_q.min_gap;
		end else if (tick) begin
			acc_d = acc_q + {1'b0, gap_diff};
		end else if (acc_q >= {1'b0, cfg_q.reduce_span}) begin
			acc_d = acc_q - {1'b0, cfg_q.reduce_span};
			gap_d = gap_q - TW'(1);
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			count_q <= '0;
			gap_q   <= RST_PASSAGE;
			acc_q   <= '0;
		end else begin
			count_q <= count_d;
			gap_q   <= gap_d;
			acc_q   <= acc_d;
		end
	end

	// Initial period, timed from green onset
	interval_timer u_init (
		.clk(CLK), .rstn(RSTN), .tick(tick),
		.load(green_start), .run(green), .load_val(init_val),
		.remain(init_rem), .done(init_done)
	);

	// Extension: starts with green and reloads while a detection stands
	interval_timer u_ext (
		.clk(CLK), .rstn(RSTN), .tick(tick),
		.load(green_start || det), .run(green), .load_val(gap_q),
		.remain(ext_rem), .done(ext_done)
	);

	// Green ceiling, held at full without a conflicting call
	interval_timer u_max (
		.clk(CLK), .rstn(RSTN), .tick(tick),
		.load(!run_gate), .run(1'b1), .load_val(cfg_q.max_green),
		.remain(max_rem), .done(max_done)
	);

	// Pre-reduction delay, same gating as the ceiling
	interval_timer u_before (
		.clk(CLK), .rstn(RSTN), .tick(tick),
		.load(!run_gate), .run(1'b1), .load_val(cfg_q.before_red),
		.remain(before_rem), .done(before_done)
	);

	// One timer serves walk then clearance
	interval_timer u_ped (
		.clk(CLK), .rstn(RSTN), .tick(tick),
		.load(ped_start || walk_end), .run(1'b1),
		.load_val(walk_end ? cfg_q.ped_clear : cfg_q.walk),
		.remain(ped_rem), .done(ped_done)
	);

	// Termination: a zero load is done one clock later, well inside 100 ms
	assign gap_out   = ext_done && !det;
	assign max_exp   = max_done && run_gate;
	assign terminate = green && init_done && (ped_q == PD_IDLE) && conf && (gap_out || max_exp);

	// Green phase state
	always_comb begin
		phase_d = phase_q;
		done_d  = terminate;
		unique case (phase_q)
			PH_OFF:   if (green_start) phase_d = PH_GREEN;
			PH_GREEN: if (terminate) phase_d = PH_OFF;
			default:  phase_d = PH_OFF;
		endcase
	end

	// Crossing service: start with green, recycle only when clear
	assign ped_start = (green_start && pin_s2_q.ped_call && !inh) ||
		(green && ped_q == PD_IDLE && pin_s2_q.ped_call && recyc_ok);
	assign walk_end  = (ped_q == PD_WALK) && ped_done;

	always_comb begin
		ped_d = ped_q;
		unique case (ped_q)
			PD_IDLE:  if (ped_start) ped_d = PD_WALK;
			PD_WALK:  if (ped_done) ped_d = PD_CLEAR;
			PD_CLEAR: if (ped_done) ped_d = PD_IDLE;
			default:  ped_d = PD_IDLE;
		endcase
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			phase_q <= PH_OFF;
			ped_q   <= PD_IDLE;
			done_q  <= 1'b0;
		end else begin
			phase_q <= phase_d;
			ped_q   <= ped_d;
			done_q  <= done_d;
		end
	end

	// Indications straight from state flops; green covers crossing service
	assign GREEN           = phase_q[1];
	assign WALK            = ped_q[1];
	assign DONT_WALK_FLASH = ped_q[2];
	assign PED_CLEARANCE   = ped_q[2];
	assign GREEN_DONE      = done_q;

	// Checks
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RSTN);

	a_max_held_reset: assert property (!run_gate |=> max_rem == $past(cfg_q.max_green))
		else $error("ceiling timer not held without conflicting call");
	a_max_count_gate: assert property ((max_rem < $past(max_rem)) && (max_rem != $past(cfg_q.max_green))
		|-> $past(run_gate))
		else $error("ceiling timer ran outside green with call");
	a_min_before_end: assert property (terminate |-> init_done ##1 !green)
		else $error("green ended before initial period");
	a_ext_det_held: assert property (det && green |=> ext_rem == $past(gap_q))
		else $error("extension timer not held full by detection");
	a_no_gap_det: assert property (green && det && !max_exp |=> green)
		else $error("gap termination during active detection");
	a_init_floor: assert property (green_start |=> init_rem >= $past(cfg_q.min_green))
		else $error("initial shorter than minimum green");
	a_ext_parallel: assert property (green_start |=> ext_rem == $past(gap_q) && green)
		else $error("extension not started with green");
	a_walk_start: assert property (green_start && pin_s2_q.ped_call && !inh |=> ped_q == PD_WALK)
		else $error("walk did not start with green");
	a_walk_length: assert property ($rose(WALK) |-> ped_rem == cfg_q.walk)
		else $error("walk loaded with wrong duration");
	a_ped_in_green: assert property (ped_q != PD_IDLE |-> GREEN)
		else $error("crossing shown without green");
	a_recycle_gate: assert property (($rose(WALK) && $past(green)) |-> $past(recyc_ok))
		else $error("crossing recycled against a call or inhibit");
	a_gap_revert: assert property (green && !conf |=> gap_q == $past(cfg_q.passage) && !reducing)
		else $error("gap not restored after call withdrawn");
	a_gap_step: assert property ((gap_q < $past(gap_q)) && $past(reducing) |-> gap_q >= cfg_q.min_gap)
		else $error("gap fell below floor");
	a_count_inc: assert property (!green && cfg_q.vol_density && det_rise && count_q != '1 && !green_start
		|=> count_q == $past(count_q) + CNT_W'(1))
		else $error("detection not counted");

	c_max_out: cover property (terminate && max_exp);
	c_gap_out: cover property (terminate && gap_out);
	c_recycle: cover property (ped_start && green);
	c_floor: cover property (reducing && gap_q == cfg_q.min_gap);

endmodule
`default_nettype wire

// >>> pkg/phase_timing_pkg.sv
`default_nettype none
package phase_timing_pkg;

	// Timer resolution: every interval counts eighths of a second
	localparam int TW            = 10;
	localparam int CNT_W         = 8;
	localparam int TICKS_PER_S   = 8;
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_NS       = 125_000_000;
	localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;

	// Fixed ceiling of the detection-scaled initial, in eighths
	localparam logic [TW-1:0] MAX_INIT_FIXED = 10'h0f0;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL        = 8'h00;
	localparam logic [7:0] OFS_MIN_GREEN   = 8'h04;
	localparam logic [7:0] OFS_PASSAGE     = 8'h08;
	localparam logic [7:0] OFS_MAX_GREEN   = 8'h0c;
	localparam logic [7:0] OFS_WALK        = 8'h10;
	localparam logic [7:0] OFS_PED_CLEAR   = 8'h14;
	localparam logic [7:0] OFS_ADDED_INIT  = 8'h18;
	localparam logic [7:0] OFS_REDUCE_SPAN = 8'h1c;
	localparam logic [7:0] OFS_BEFORE_RED  = 8'h20;
	localparam logic [7:0] OFS_MIN_GAP     = 8'h24;
	localparam logic [7:0] OFS_MAX_INIT    = 8'h28;
	localparam logic [7:0] OFS_STATUS      = 8'h2c;
	localparam logic [7:0] OFS_COUNT       = 8'h30;

	// Field positions
	localparam int CTRL_VD_BIT   = 0;
	localparam int CTRL_MIS_BIT  = 1;
	localparam int ST_GREEN_BIT  = 0;
	localparam int ST_WALK_BIT   = 1;
	localparam int ST_CLEAR_BIT  = 2;
	localparam int ST_MAXOUT_BIT = 3;
	localparam int ST_GAPOUT_BIT = 4;
	localparam int ST_REDUCE_BIT = 5;
	localparam int ST_MINOK_BIT  = 6;
	localparam int ST_GAP_LSB    = 16;

	// Reset values, in eighths of a second
	localparam logic [TW-1:0] RST_MIN_GREEN   = 10'h028;
	localparam logic [TW-1:0] RST_PASSAGE     = 10'h018;
	localparam logic [TW-1:0] RST_MAX_GREEN   = 10'h0f0;
	localparam logic [TW-1:0] RST_WALK        = 10'h038;
	localparam logic [TW-1:0] RST_PED_CLEAR   = 10'h060;
	localparam logic [TW-1:0] RST_ADDED_INIT  = 10'h00c;
	localparam logic [TW-1:0] RST_REDUCE_SPAN = 10'h078;
	localparam logic [TW-1:0] RST_BEFORE_RED  = 10'h050;
	localparam logic [TW-1:0] RST_MIN_GAP     = 10'h008;
	localparam logic [TW-1:0] RST_MAX_INIT    = 10'h0f0;

	typedef struct packed {
		logic          vol_density;
		logic          max_init_set;
		logic [TW-1:0] min_green;
		logic [TW-1:0] passage;
		logic [TW-1:0] max_green;
		logic [TW-1:0] walk;
		logic [TW-1:0] ped_clear;
		logic [TW-1:0] added_init;
		logic [TW-1:0] reduce_span;
		logic [TW-1:0] before_red;
		logic [TW-1:0] min_gap;
		logic [TW-1:0] max_init;
	} cfg_t;

	localparam cfg_t CFG_RST = '{1'b0, 1'b0, RST_MIN_GREEN, RST_PASSAGE, RST_MAX_GREEN, RST_WALK,
		RST_PED_CLEAR, RST_ADDED_INIT, RST_REDUCE_SPAN, RST_BEFORE_RED, RST_MIN_GAP, RST_MAX_INIT};

	typedef struct packed {
		logic veh_det;
		logic ped_call;
		logic conflict;
		logic inhibit;
		logic phase_go;
	} pins_t;

	typedef enum logic [1:0] {PH_OFF = 2'b01, PH_GREEN = 2'b10} phase_t;
	typedef enum logic [2:0] {PD_IDLE = 3'b001, PD_WALK = 3'b010, PD_CLEAR = 3'b100} ped_t;

	// Larger of two settings
	function automatic logic [TW-1:0] lim_max(input logic [TW-1:0] a, input logic [TW-1:0] b);
		lim_max = (a > b) ? a : b;
	endfunction

	// Clip a wide product to a ceiling
	function automatic logic [TW-1:0] lim_clip(input logic [TW+CNT_W-1:0] v, input logic [TW-1:0] cap);
		lim_clip = (v > {{CNT_W{1'b0}}, cap}) ? cap : v[TW-1:0];
	endfunction

endpackage
`default_nettype wire

// >>> hdl/tick_gen.sv
`timescale 1ns/100ps
`default_nettype none
module tick_gen
	import phase_timing_pkg::*;
#(
	parameter int DIV = TICK_CYCLES
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rstn,
	// Time base
	output logic      tick
);

	localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic          tick_q;
	logic          tick_d;

	// Wrap at DIV-1 and flag the wrap as a one-cycle enable
	always_comb begin
		tick_d = (cnt_q == CW'(DIV - 1));
		cnt_d  = tick_d ? '0 : cnt_q + CW'(1);
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_q  <= '0;
			tick_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign tick = tick_q;

endmodule
`default_nettype wire

// >>> hdl/interval_timer.sv
`timescale 1ns/100ps
`default_nettype none
module interval_timer
	import phase_timing_pkg::*;
#(
	parameter int W = TW
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rstn,
	// Control
	input  wire logic         tick,
	input  wire logic         load,
	input  wire logic         run,
	input  wire logic [W-1:0] load_val,
	// State
	output logic [W-1:0]      remain,
	output logic              done
);

	logic [W-1:0] remain_q;
	logic [W-1:0] remain_d;

	// Load wins over counting; a zero load reads as done one cycle later
	always_comb begin
		remain_d = remain_q;
		if (load) begin
			remain_d = load_val;
		end else if (run && tick && remain_q != '0) begin
			remain_d = remain_q - W'(1);
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			remain_q <= '0;
		end else begin
			remain_q <= remain_d;
		end
	end

	assign remain = remain_q;
	assign done   = (remain_q == '0);

endmodule
`default_nettype wire

// >>> dv/field_side_model.sv
`timescale 1ns/100ps
`default_nettype none
module field_side_model (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rstn,
	// Bench requests and display feedback
	input  wire logic det_on,
	input  wire logic press,
	input  wire logic walk,
	// Field pins
	output logic      veh_det,
	output logic      ped_call
);
	logic call_d;
	logic call_q;

	// Presence detector follows occupancy directly
	assign veh_det = det_on;

	// Call memory: a press is stored until walk shows
	always_comb begin
		call_d = call_q;
		if (walk)
			call_d = 1'b0;
		else if (press)
			call_d = 1'b1;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			call_q <= 1'b0;
		else
			call_q <= call_d;
	end

	assign ped_call = call_q;
endmodule
`default_nettype wire

// >>> dv/test_phase_green_ped_timing.sv
`timescale 1ns/100ps
`default_nettype none
module test_phase_green_ped_timing import phase_timing_pkg::*;;
	logic        clk, rstn, psel, penable, pwrite, det_on, press, conflict, inhibit, go;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, er, veh_det, ped_call, green, walk, dwf, pclr, gdone;
	int          n_mismatch, checks_done, cyc;
	logic [9:0]  rv [10] = '{RST_MIN_GREEN, RST_PASSAGE, RST_MAX_GREEN, RST_WALK, RST_PED_CLEAR,
		RST_ADDED_INIT, RST_REDUCE_SPAN, RST_BEFORE_RED, RST_MIN_GAP, RST_MAX_INIT};

	// Short tick of 10 cycles per eighth keeps the tested intervals to a few hundred cycles
	phase_green_ped_timing #(.TICK_DIV(10)) dut (.CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.VEH_DET(veh_det), .PED_CALL(ped_call), .CONFLICT_CALL(conflict), .CROSSING_SERVICE_INHIBIT(inhibit),
		.PHASE_GO(go), .GREEN(green), .WALK(walk), .DONT_WALK_FLASH(dwf), .PED_CLEARANCE(pclr),
		.GREEN_DONE(gdone));
	field_side_model field (.clk(clk), .rstn(rstn), .det_on(det_on), .press(press), .walk(walk),
		.veh_det(veh_det), .ped_call(ped_call));

	task check_eq(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task print_verdict;
		if (n_mismatch == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Pins change by NBA at the edge; checks read the values settled before it
	task step;
		@(posedge clk);
	endtask

	// One APB transfer; answer taken at the access edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task t_regs;
		for (int i = 0; i < 10; i++) begin
			apb(1'b0, 8'(4 * i + 4), 32'h0);
			check_eq(rd, {22'h0, rv[i]});
		end
		apb(1'b1, OFS_PASSAGE, 32'h48);
		apb(1'b0, OFS_PASSAGE, 32'h0);
		check_eq(rd, 32'h48);
		apb(1'b1, OFS_MAX_INIT, 32'h1e0);
		apb(1'b0, OFS_MAX_INIT, 32'h0);
		check_eq(rd, 32'h1e0);
		apb(1'b0, 8'h34, 32'h0);
		check_eq(rd, 32'h0);
		check_eq(er, 1'b1);
		apb(1'b1, OFS_STATUS, 32'hff);
		check_eq(er, 1'b1);
	endtask

	// Detections while not green are counted
	task t_count;
		apb(1'b1, OFS_CTRL, 32'h1);
		repeat (3) begin
			det_on <= 1'b1;
			repeat (3) step;
			det_on <= 1'b0;
			repeat (3) step;
		end
		apb(1'b0, OFS_COUNT, 32'h0);
		check_eq(rd, 32'h3);
		apb(1'b1, OFS_CTRL, 32'h0);
	endtask

	// Walk then clearance, green shown throughout
	task t_walk;
		int n;
		apb(1'b1, OFS_MIN_GREEN, 32'h4);
		apb(1'b1, OFS_PASSAGE, 32'h2);
		apb(1'b1, OFS_WALK, 32'h2);
		apb(1'b1, OFS_PED_CLEAR, 32'h3);
		press <= 1'b1;
		step;
		press <= 1'b0;
		go <= 1'b1;
		repeat (4) step;
		check_eq({green, walk}, 2'b11);
		for (n = 0; walk === 1'b1 && n < 60; n++) begin
			step;
			check_eq(green, 1'b1);
		end
		check_eq(n inside {[10:30]}, 1'b1);
		check_eq({dwf, pclr}, 2'b11);
		for (n = 0; pclr === 1'b1 && n < 60; n++) begin
			step;
			check_eq(green, 1'b1);
		end
		check_eq(n inside {[20:40]}, 1'b1);
	endtask

	// Recycle only without inhibit or conflict, then gap out
	task t_recycle;
		int n;
		inhibit <= 1'b1;
		press <= 1'b1;
		step;
		press <= 1'b0;
		repeat (20) step;
		check_eq(walk, 1'b0);
		inhibit <= 1'b0;
		repeat (5) step;
		check_eq(walk, 1'b1);
		for (n = 0; (walk | pclr) === 1'b1 && n < 100; n++)
			step;
		conflict <= 1'b1;
		press <= 1'b1;
		step;
		press <= 1'b0;
		for (n = 0; green === 1'b1 && n < 60; n++) begin
			check_eq(walk, 1'b0);
			step;
		end
		check_eq(n < 60, 1'b1);
		check_eq(gdone, 1'b1);
		step;
		check_eq(gdone, 1'b0);
	endtask

	// Held detection: green ends by ceiling, never before minimum
	task t_hold(input logic [31:0] mg, input int dly, input int lo, input int hi);
		int n;
		apb(1'b1, OFS_MIN_GREEN, mg);
		apb(1'b1, OFS_MAX_GREEN, 32'hc);
		conflict <= (dly == 0);
		det_on <= 1'b1;
		go <= 1'b0;
		repeat (3) step;
		go <= 1'b1;
		repeat (4) step;
		for (n = 0; green === 1'b1 && n < 400; n++) begin
			if (n == dly)
				conflict <= 1'b1;
			step;
		end
		check_eq(n inside {[lo:hi]}, 1'b1);
		det_on <= 1'b0;
		repeat (30) step;
	endtask

	// Volume density: capped initial and gap reduced to the floor
	task t_vd;
		int n;
		apb(1'b1, OFS_CTRL, 32'h3);
		apb(1'b1, OFS_MAX_INIT, 32'h10);
		apb(1'b1, OFS_BEFORE_RED, 32'h1);
		apb(1'b1, OFS_REDUCE_SPAN, 32'h2);
		apb(1'b1, OFS_PASSAGE, 32'h10);
		apb(1'b1, OFS_MIN_GAP, 32'h4);
		go <= 1'b0;
		repeat (3) begin
			det_on <= 1'b1;
			repeat (3) step;
			det_on <= 1'b0;
			repeat (3) step;
		end
		go <= 1'b1;
		repeat (50) step;
		apb(1'b0, OFS_STATUS, 32'h0);
		check_eq(rd, (32'h4 << ST_GAP_LSB) | (32'h1 << ST_REDUCE_BIT) | (32'h1 << ST_GREEN_BIT));
		for (n = 0; green === 1'b1 && n < 400; n++)
			step;
		check_eq(n inside {[100:125]}, 1'b1);
	endtask

	// Clock, reset and hang limit
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			print_verdict;
		end
	end

	initial begin
		{rstn, psel, penable, pwrite, det_on, press, conflict, inhibit, go} = '0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		t_regs;
		t_count;
		t_walk;
		t_recycle;
		t_hold(32'h14, 0, 190, 215);
		t_hold(32'h4, 0, 110, 135);
		t_hold(32'h4, 100, 210, 240);
		t_vd;
		print_verdict;
	end
endmodule
`default_nettype wire
